//--- shared/ffc_pkg.sv
// Shared constants and types for the serial frame format block
package ffc_pkg;

    // Register indices on the 3-bit register address
    localparam logic [2:0] FFC_ADDR_FMT  = 3'h0;
    localparam logic [2:0] FFC_ADDR_BAUD = 3'h1;
    localparam logic [2:0] FFC_ADDR_CTRL = 3'h2;
    localparam logic [2:0] FFC_ADDR_TXH  = 3'h3;
    localparam logic [2:0] FFC_ADDR_STAT = 3'h4;
    localparam logic [2:0] FFC_ADDR_RXD  = 3'h5;

    // Control register bit positions
    localparam int FFC_CTRL_TX_EN  = 0;
    localparam int FFC_CTRL_RX_EN  = 1;
    localparam int FFC_CTRL_MP_BIT = 2;

    // Status register bit positions
    localparam int FFC_STAT_SPACE  = 0;
    localparam int FFC_STAT_EMPTY  = 1;
    localparam int FFC_STAT_BUSY   = 2;
    localparam int FFC_STAT_RXFULL = 3;
    localparam int FFC_STAT_PARERR = 4;
    localparam int FFC_STAT_FRMERR = 5;
    localparam int FFC_STAT_RXMP   = 6;

    // Reset values
    localparam logic [7:0] FFC_FMT_RESET  = 8'h00;
    localparam logic [7:0] FFC_BAUD_RESET = 8'hFF;
    localparam logic [7:0] FFC_CTRL_RESET = 8'h00;

    // Prescaler selection codes and their terminal counts
    localparam logic [1:0] FFC_PRE_DIV1  = 2'h0;
    localparam logic [1:0] FFC_PRE_DIV4  = 2'h1;
    localparam logic [1:0] FFC_PRE_DIV16 = 2'h2;
    localparam logic [5:0] FFC_TERM_DIV1  = 6'h00;
    localparam logic [5:0] FFC_TERM_DIV4  = 6'h03;
    localparam logic [5:0] FFC_TERM_DIV16 = 6'h0F;
    localparam logic [5:0] FFC_TERM_DIV64 = 6'h3F;

    // Data bits per character, minus one
    localparam logic [2:0] FFC_LAST_BIT8 = 3'h7;
    localparam logic [2:0] FFC_LAST_BIT7 = 3'h6;

    localparam int FFC_BUF_DEPTH = 2;

    // Frame format register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       sync_mode;
        logic       seven_bit_char_select;
        logic       parity_enable;
        logic       parity_odd_select;
        logic       two_stop;
        logic       multidrop_enable;
        logic       prescale_sel_hi;
        logic       prescale_sel_lo;
    } ffc_fmt_t;

    // Effective frame settings after mode qualification
    typedef struct packed {
        logic       sync_mode;
        logic       seven;
        logic       par_on;
        logic       par_odd;
        logic       two_stop;
        logic       mp_on;
        logic [1:0] presc;
    } ffc_cfg_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} ffc_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} ffc_rx_state_t;

endpackage

//--- verilog/ffc_serial_top.sv
// Serial unit with frame format register, transmit buffer, transmitter and receiver
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ffc_serial_top
    import ffc_pkg::*;
#(
    parameter int BUF_DEPTH = FFC_BUF_DEPTH
) (
    input  wire logic       CLK_IN,
    input  wire logic       RSTN_IN,
    input  wire logic       CE_IN,
    input  wire logic       LOWPWR_IN,
    input  wire logic [2:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    input  wire logic       RXD_IN,
    output logic      [7:0] RDATA_OUT,
    output logic            TXD_OUT,
    output logic            SCK_OUT,
    output logic            SCK_OE_OUT,
    output logic            BUF_READY_OUT
);

    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    generate
        if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_depth_check
            $error("BUF_DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        ffc_fmt_t                    fmt;
        logic [7:0]                  baud;
        logic [7:0]                  ctrl;
        logic [7:0]                  rdata;
        logic [5:0]                  pre_cnt;
        logic [BUF_DEPTH-1:0][7:0]   buf_mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
        logic                        buf_ready;
        ffc_tx_state_t               tx_state;
        logic [7:0]                  tx_shifter;
        logic [2:0]                  tx_bits;
        logic [7:0]                  tx_cnt;
        logic                        tx_extra;
        logic                        tx_stop_left;
        logic                        txd;
        logic                        sck;
        logic                        sck_oe;
        ffc_rx_state_t               rx_state;
        logic [7:0]                  rx_sh;
        logic [2:0]                  rx_bits;
        logic [7:0]                  rx_cnt;
        logic                        rx_extra;
        logic [7:0]                  rx_data;
        logic                        rx_full;
        logic                        par_err;
        logic                        frm_err;
        logic                        rx_mp;
    } ffc_state_t;

    localparam ffc_state_t S_RESET = '{
        fmt:          ffc_fmt_t'(FFC_FMT_RESET),
        baud:         FFC_BAUD_RESET,
        ctrl:         FFC_CTRL_RESET,
        buf_ready:    1'b1,
        tx_state:     TX_IDLE,
        txd:          1'b1,
        sck:          1'b1,
        rx_state:     RX_IDLE,
        default:      '0
    };

    // Qualify raw format bits by mode
    function automatic ffc_cfg_t eff_cfg(input ffc_fmt_t f);
        ffc_cfg_t c;
        c.sync_mode = f.sync_mode;
        c.seven     = ~f.sync_mode & f.seven_bit_char_select;
        c.mp_on     = ~f.sync_mode & f.multidrop_enable;
        c.par_on    = ~f.sync_mode & ~f.multidrop_enable & f.parity_enable;
        c.par_odd   = f.parity_odd_select;
        c.two_stop  = f.two_stop;
        c.presc     = {f.prescale_sel_hi, f.prescale_sel_lo};
        return c;
    endfunction

    // Terminal count of the baud generator input divider
    function automatic logic [5:0] pre_term(input logic [1:0] sel);
        case (sel)
            FFC_PRE_DIV1:  pre_term = FFC_TERM_DIV1;
            FFC_PRE_DIV4:  pre_term = FFC_TERM_DIV4;
            FFC_PRE_DIV16: pre_term = FFC_TERM_DIV16;
            default:       pre_term = FFC_TERM_DIV64;
        endcase
    endfunction

    ffc_state_t s;
    ffc_state_t next_s;
    ffc_cfg_t   cfg;
    logic       tick;
    logic       tx_end;
    logic       tx_half;
    logic       rx_pt;
    logic       push;
    logic       pop;
    logic       tx_en;
    logic       rx_en;
    logic [7:0] load_byte;
    logic [7:0] rx_byte;
    logic       clr_full;
    logic       clr_par;
    logic       clr_frm;
    logic       set_full;
    logic       set_par;
    logic       set_frm;

    always_comb begin
        next_s    = s;
        cfg       = eff_cfg(s.fmt);
        tx_en     = s.ctrl[FFC_CTRL_TX_EN];
        rx_en     = s.ctrl[FFC_CTRL_RX_EN];
        tick      = (s.pre_cnt == pre_term(cfg.presc));
        tx_end    = tick && (s.tx_cnt == 8'h00);
        // Clock rises at mid bit; a bit rate value of 0 leaves no room for a high half
        tx_half   = tick && ({1'b0, s.tx_cnt} == (({1'b0, s.baud} + 9'h001) >> 1));
        rx_pt     = tick && (s.rx_cnt == 8'h00);
        push      = WR_IN && (ADDR_IN == FFC_ADDR_TXH) && (s.count != (PW+1)'(BUF_DEPTH));
        pop       = 1'b0;
        load_byte = s.buf_mem[s.rd_ptr];
        rx_byte   = cfg.seven ? {1'b0, s.rx_sh[7:1]} : s.rx_sh;
        clr_full  = 1'b0;
        clr_par   = 1'b0;
        clr_frm   = 1'b0;
        set_full  = 1'b0;
        set_par   = 1'b0;
        set_frm   = 1'b0;
        next_s.rdata   = 8'h00;
        next_s.pre_cnt = tick ? 6'h00 : s.pre_cnt + 6'h01;

        // Register writes
        if (WR_IN) begin
            case (ADDR_IN)
                FFC_ADDR_FMT:  next_s.fmt = ffc_fmt_t'(WDATA_IN);
                FFC_ADDR_BAUD: next_s.baud = WDATA_IN;
                FFC_ADDR_CTRL: next_s.ctrl = WDATA_IN;
                FFC_ADDR_STAT: begin
                    clr_full = WDATA_IN[FFC_STAT_RXFULL];
                    clr_par  = WDATA_IN[FFC_STAT_PARERR];
                    clr_frm  = WDATA_IN[FFC_STAT_FRMERR];
                end
                default: ;
            endcase
        end

        // Register reads, data valid in the following cycle only
        if (RD_IN) begin
            case (ADDR_IN)
                FFC_ADDR_FMT:  next_s.rdata = s.fmt;
                FFC_ADDR_BAUD: next_s.rdata = s.baud;
                FFC_ADDR_CTRL: next_s.rdata = s.ctrl;
                FFC_ADDR_TXH:  next_s.rdata = s.buf_mem[s.wr_ptr - PW'(1)];
                FFC_ADDR_STAT: begin
                    next_s.rdata[FFC_STAT_SPACE]  = s.buf_ready;
                    next_s.rdata[FFC_STAT_EMPTY]  = (s.count == '0);
                    next_s.rdata[FFC_STAT_BUSY]   = (s.tx_state != TX_IDLE);
                    next_s.rdata[FFC_STAT_RXFULL] = s.rx_full;
                    next_s.rdata[FFC_STAT_PARERR] = s.par_err;
                    next_s.rdata[FFC_STAT_FRMERR] = s.frm_err;
                    next_s.rdata[FFC_STAT_RXMP]   = s.rx_mp;
                end
                FFC_ADDR_RXD: begin
                    next_s.rdata = s.rx_data;
                    clr_full     = 1'b1;
                end
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Bit timers reload from the bit rate register on each expiry
        if (tick) begin
            next_s.tx_cnt = (s.tx_cnt == 8'h00) ? s.baud : s.tx_cnt - 8'h01;
            next_s.rx_cnt = (s.rx_cnt == 8'h00) ? s.baud : s.rx_cnt - 8'h01;
        end

        // Transmitter
        case (s.tx_state)
            TX_IDLE: begin
                next_s.txd = 1'b1;
                next_s.sck = 1'b1;
                if (tx_en && s.count != '0) begin
                    pop = 1'b1;
                    next_s.tx_shifter = cfg.seven ? {1'b0, load_byte[6:0]} : load_byte;
                    next_s.tx_bits    = cfg.seven ? FFC_LAST_BIT7 : FFC_LAST_BIT8;
                    next_s.tx_cnt     = s.baud;
                    next_s.pre_cnt    = 6'h00;
                    next_s.tx_extra   = cfg.mp_on ? s.ctrl[FFC_CTRL_MP_BIT]
                                      : (^next_s.tx_shifter) ^ cfg.par_odd;
                    if (cfg.sync_mode) begin
                        next_s.tx_state = TX_DATA;
                        next_s.txd      = load_byte[0];
                        next_s.sck      = 1'b0;
                    end else begin
                        next_s.tx_state = TX_START;
                        next_s.txd      = 1'b0;
                    end
                end
            end
            TX_START: begin
                if (tx_end) begin
                    next_s.tx_state = TX_DATA;
                    next_s.txd      = s.tx_shifter[0];
                end
            end
            TX_DATA: begin
                if (cfg.sync_mode && tx_half) begin
                    next_s.sck = 1'b1;
                    if (rx_en) begin
                        next_s.rx_sh = {RXD_IN, s.rx_sh[7:1]};
                    end
                end
                if (tx_end) begin
                    next_s.tx_shifter = s.tx_shifter >> 1;
                    if (s.tx_bits != 3'h0) begin
                        next_s.tx_bits = s.tx_bits - 3'h1;
                        next_s.txd     = s.tx_shifter[1];
                        next_s.sck     = ~cfg.sync_mode;
                    end else if (cfg.sync_mode) begin
                        next_s.tx_state = TX_IDLE;
                        next_s.txd      = 1'b1;
                        if (rx_en) begin
                            set_full       = 1'b1;
                            next_s.rx_data = next_s.rx_sh;
                        end
                    end else if (cfg.par_on || cfg.mp_on) begin
                        next_s.tx_state = TX_EXTRA;
                        next_s.txd      = s.tx_extra;
                    end else begin
                        next_s.tx_state     = TX_STOP;
                        next_s.txd          = 1'b1;
                        next_s.tx_stop_left = cfg.two_stop;
                    end
                end
            end
            TX_EXTRA: begin
                if (tx_end) begin
                    next_s.tx_state     = TX_STOP;
                    next_s.txd          = 1'b1;
                    next_s.tx_stop_left = cfg.two_stop;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    if (s.tx_stop_left) begin
                        next_s.tx_stop_left = 1'b0;
                    end else begin
                        next_s.tx_state = TX_IDLE;
                    end
                end
            end
            default: next_s.tx_state = TX_IDLE;
        endcase

        // Asynchronous receiver, idle in synchronous mode
        if (!rx_en || cfg.sync_mode) begin
            next_s.rx_state = RX_IDLE;
        end else begin
            case (s.rx_state)
                RX_IDLE: begin
                    if (!RXD_IN) begin
                        next_s.rx_state = RX_START;
                        next_s.rx_cnt   = s.baud >> 1;
                    end
                end
                RX_START: begin
                    if (rx_pt) begin
                        next_s.rx_state = RXD_IN ? RX_IDLE : RX_DATA;
                        next_s.rx_bits  = cfg.seven ? FFC_LAST_BIT7 : FFC_LAST_BIT8;
                    end
                end
                RX_DATA: begin
                    if (rx_pt) begin
                        next_s.rx_sh = {RXD_IN, s.rx_sh[7:1]};
                        if (s.rx_bits != 3'h0) begin
                            next_s.rx_bits = s.rx_bits - 3'h1;
                        end else begin
                            next_s.rx_state = (cfg.par_on || cfg.mp_on) ? RX_EXTRA : RX_STOP;
                        end
                    end
                end
                RX_EXTRA: begin
                    if (rx_pt) begin
                        next_s.rx_extra = RXD_IN;
                        next_s.rx_state = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_pt) begin
                        next_s.rx_state = RX_IDLE;
                        next_s.rx_data  = rx_byte;
                        set_full        = 1'b1;
                        set_frm         = ~RXD_IN;
                        set_par         = cfg.par_on && ((^rx_byte ^ s.rx_extra) != cfg.par_odd);
                        if (cfg.mp_on) begin
                            next_s.rx_mp = s.rx_extra;
                        end
                    end
                end
                default: next_s.rx_state = RX_IDLE;
            endcase
        end

        // Sticky receive flags, a set in the clearing cycle wins
        next_s.rx_full = (s.rx_full & ~clr_full) | set_full;
        next_s.par_err = (s.par_err & ~clr_par) | set_par;
        next_s.frm_err = (s.frm_err & ~clr_frm) | set_frm;

        // Two-entry transmit buffer between software and the shifter
        if (push) begin
            next_s.buf_mem[s.wr_ptr] = WDATA_IN;
            next_s.wr_ptr            = s.wr_ptr + PW'(1);
        end
        if (pop) begin
            next_s.rd_ptr = s.rd_ptr + PW'(1);
        end
        next_s.count     = s.count + (PW+1)'(push) - (PW+1)'(pop);
        next_s.buf_ready = (next_s.count != (PW+1)'(BUF_DEPTH));
        next_s.sck_oe    = cfg.sync_mode & tx_en;

        if (LOWPWR_IN) begin
            next_s = S_RESET;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s <= S_RESET;
        end else if (CE_IN) begin
            s <= next_s;
        end
    end

    assign RDATA_OUT     = s.rdata;
    assign TXD_OUT       = s.txd;
    assign SCK_OUT       = s.sck;
    assign SCK_OE_OUT    = s.sck_oe;
    assign BUF_READY_OUT = s.buf_ready;

endmodule

`default_nettype wire

//--- sim/ffc_serial_properties.sv
// Concurrent checks on the serial unit ports
`timescale 1ns/1ps
`default_nettype none
module ffc_serial_properties
    import ffc_pkg::*;
(
    input wire logic       CLK_IN,
    input wire logic       RSTN_IN,
    input wire logic       CE_IN,
    input wire logic       LOWPWR_IN,
    input wire logic [2:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic       WR_IN,
    input wire logic       RD_IN,
    input wire logic       RXD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic       TXD_OUT,
    input wire logic       SCK_OUT,
    input wire logic       SCK_OE_OUT,
    input wire logic       BUF_READY_OUT
);
    logic [7:0] fmt_shadow;
    logic       sync_bit;
    logic       txh_wr;
    logic       fmt_rd;
    assign sync_bit = fmt_shadow[7];
    assign txh_wr = CE_IN && WR_IN && ADDR_IN == FFC_ADDR_TXH;
    assign fmt_rd = CE_IN && RD_IN && !LOWPWR_IN && ADDR_IN == FFC_ADDR_FMT;
    // Mirror of the format register as software wrote it
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN)
            fmt_shadow <= FFC_FMT_RESET;
        else if (CE_IN && LOWPWR_IN)
            fmt_shadow <= FFC_FMT_RESET;
        else if (CE_IN && WR_IN && ADDR_IN == FFC_ADDR_FMT)
            fmt_shadow <= WDATA_IN;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    fmt_read_a: assert property (fmt_rd |=> RDATA_OUT == $past(fmt_shadow))
        else $error("format register read differs from last write");
    lowpwr_clear_a: assert property (CE_IN && LOWPWR_IN ##1 !WR_IN ##1 fmt_rd |=> RDATA_OUT == 8'h00)
        else $error("format register not cleared by low power");
    read_pulse_a: assert property ($past(CE_IN) && !$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (CE_IN && RD_IN && ADDR_IN > FFC_ADDR_RXD |=> RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    async_no_oe_a: assert property (!sync_bit && !$past(sync_bit) && !$past(sync_bit, 2) |-> !SCK_OE_OUT)
        else $error("clock pin driven in async mode");
    async_sck_idle_a: assert property (!sync_bit && !$past(sync_bit) && !$past(sync_bit, 2) |-> SCK_OUT)
        else $error("serial clock moves in async mode");
    reset_line_a: assert property ($rose(RSTN_IN) |-> TXD_OUT && SCK_OUT && !SCK_OE_OUT && BUF_READY_OUT)
        else $error("outputs not idle after reset");
    lowpwr_idle_a: assert property (CE_IN && LOWPWR_IN |=> TXD_OUT && !SCK_OE_OUT && BUF_READY_OUT)
        else $error("outputs not idle after low power");
    buf_fall_a: assert property ($fell(BUF_READY_OUT) |-> $past(txh_wr) || $past(txh_wr, 2))
        else $error("buffer filled without a write");
endmodule
bind ffc_serial_top ffc_serial_properties i_props (.CLK_IN, .RSTN_IN, .CE_IN, .LOWPWR_IN, .ADDR_IN, .WDATA_IN,
    .WR_IN, .RD_IN, .RXD_IN, .RDATA_OUT, .TXD_OUT, .SCK_OUT, .SCK_OE_OUT, .BUF_READY_OUT);
`default_nettype wire

//--- sim/ffc_peer.sv
// Remote serial device: captures sent frames and sends frames back
`timescale 1ns/1ps
`default_nettype none
module ffc_peer (
    input  wire logic clk_in,
    input  wire logic txd_in,
    input  wire logic sck_in,
    output logic      rxd_out
);
    initial rxd_out = 1'b1;
    // Finds the start edge, then samples every bit at its middle
    task automatic catch_async(input int per, input int n, output logic [19:0] b);
        int w;
        begin
            b = '0;
            w = 0;
            do begin
                @(negedge clk_in);
                w++;
            end while (txd_in !== 1'b0 && w < 20000);
            repeat (per / 2) @(negedge clk_in);
            for (int i = 0; i < n; i++) begin
                if (i > 0) repeat (per) @(negedge clk_in);
                b[i] = txd_in;
            end
        end
    endtask
    // Counts clock rises over a window, shifting data in LSB first
    task automatic catch_sync(input int win, output logic [7:0] b, output int n);
        logic prev;
        begin
            b = '0;
            n = 0;
            prev = 1'b1;
            repeat (win) begin
                @(negedge clk_in);
                if (sck_in && !prev) begin
                    b = {txd_in, b[7:1]};
                    n++;
                end
                prev = sck_in;
            end
        end
    endtask
    // Line idles high between frames
    task automatic send(input int per, input int n, input logic [19:0] b);
        begin
            for (int i = 0; i < n; i++) begin
                @(posedge clk_in);
                rxd_out <= b[i];
                repeat (per - 1) @(posedge clk_in);
            end
            @(posedge clk_in);
            rxd_out <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

//--- sim/ffc_serial_top_tb.sv
// Self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module ffc_serial_top_tb
    import ffc_pkg::*;
();
    logic        clk, rstn, ce, lowpwr, wr_s, rd_s, rxd, txd, sck, sck_oe, buf_ready;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, d8, g8;
    logic [19:0] ex, got, got2;
    int          n, gn, num_errors, n_checks;
    logic [7:0]  tf [6] = '{8'h00, 8'h61, 8'h3A, 8'h37, 8'h40, 8'hF8};
    logic [7:0]  td [6] = '{8'h01, 8'hC3, 8'h96, 8'hA5, 8'h7F, 8'hEB};
    int          tn [6] = '{10, 10, 12, 11, 9, 8};
    ffc_serial_top i_dut (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .LOWPWR_IN(lowpwr), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RXD_IN(rxd), .RDATA_OUT(rdata), .TXD_OUT(txd),
        .SCK_OUT(sck), .SCK_OE_OUT(sck_oe), .BUF_READY_OUT(buf_ready));
    ffc_peer i_peer (.clk_in(clk), .txd_in(txd), .sck_in(sck), .rxd_out(rxd));
    // Expected async frame, start bit first; multidrop bit sent as 1
    function automatic logic [19:0] frm(input logic [7:0] f, input logic [7:0] d, output int k);
        logic [7:0] x;
        begin
            x = f[6] ? {1'b0, d[6:0]} : d;
            frm = '0;
            k = 1;
            for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
                frm[k] = x[i];
                k++;
            end
            if (f[2] || f[5]) begin
                frm[k] = f[2] ? 1'b1 : ^x ^ f[4];
                k++;
            end
            frm[k] = 1'b1;
            k = k + 1 + f[3];
            frm[k - 1] = 1'b1;
        end
    endfunction
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic idle_wait;
        int w;
        begin
            w = 0;
            do begin
                rd(FFC_ADDR_STAT, d8);
                w++;
            end while ((d8[FFC_STAT_BUSY] !== 1'b0 || d8[FFC_STAT_EMPTY] !== 1'b1) && w < 2000);
            if (w >= 2000) num_errors++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        summarize();
    end
    initial begin
        {rstn, lowpwr, wr_s, rd_s, addr, wdata} = '0;
        ce = 1'b1;
        n_checks = 0;
        num_errors = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(FFC_ADDR_FMT, d8);
        `CHK(d8, FFC_FMT_RESET)
        `CHK({txd, buf_ready, sck_oe}, 3'b110)
        wr(FFC_ADDR_BAUD, 8'h01);
        wr(3'h6, 8'hAA);
        rd(3'h6, d8);
        `CHK(d8, 8'h00)
        for (int i = 0; i < 6; i++) begin
            idle_wait();
            wr(FFC_ADDR_CTRL, 8'h00);
            wr(FFC_ADDR_FMT, tf[i]);
            rd(FFC_ADDR_FMT, d8);
            `CHK(d8, tf[i])
            // Multidrop bit value 1; receiver also on in the synchronous row
            wr(FFC_ADDR_CTRL, {5'h00, tf[i][2], tf[i][7], 1'b1});
            wr(FFC_ADDR_TXH, td[i]);
            `CHK(sck_oe, tf[i][7])
            if (tf[i][7]) begin
                i_peer.catch_sync(60, g8, gn);
                `CHK(gn, tn[i])
                `CHK(g8, td[i])
                rd(FFC_ADDR_RXD, d8);
                `CHK(d8, 8'hFF)
            end else begin
                ex = frm(tf[i], td[i], n);
                i_peer.catch_async(2 << (2 * tf[i][1:0]), tn[i], got);
                `CHK(got, ex)
            end
        end
        idle_wait();
        wr(FFC_ADDR_CTRL, 8'h00);
        wr(FFC_ADDR_FMT, 8'h20);
        wr(FFC_ADDR_CTRL, 8'h02);
        for (int k = 0; k < 3; k++) begin
            ex = frm(8'h20, 8'h5A, n) ^ (k == 0 ? 20'h0 : 20'h1 << (8 + k));
            i_peer.send(2, n, ex);
            rd(FFC_ADDR_STAT, d8);
            `CHK(d8[5:4], {k == 2, k == 1})
            rd(FFC_ADDR_RXD, d8);
            `CHK(d8, 8'h5A)
            wr(FFC_ADDR_STAT, 8'h38);
        end
        wr(FFC_ADDR_CTRL, 8'h00);
        wr(FFC_ADDR_FMT, 8'h28);
        wr(FFC_ADDR_CTRL, 8'h02);
        got = frm(8'h20, 8'hC3, n);
        ex = frm(8'h20, 8'h3C, n);
        i_peer.send(2, n, got);
        i_peer.send(2, n, ex);
        rd(FFC_ADDR_STAT, d8);
        `CHK(d8[5:3], 3'b001)
        rd(FFC_ADDR_RXD, d8);
        `CHK(d8, 8'h3C)
        wr(FFC_ADDR_CTRL, 8'h00);
        wr(FFC_ADDR_FMT, 8'h00);
        wr(FFC_ADDR_TXH, 8'h11);
        wr(FFC_ADDR_TXH, 8'h22);
        wr(FFC_ADDR_TXH, 8'h33);
        `CHK({buf_ready, txd}, 2'b01)
        wr(FFC_ADDR_CTRL, 8'h01);
        i_peer.catch_async(2, 10, got);
        i_peer.catch_async(2, 10, got2);
        `CHK(got, frm(8'h00, 8'h11, n))
        `CHK(got2, frm(8'h00, 8'h22, n))
        idle_wait();
        wr(FFC_ADDR_FMT, 8'h5C);
        ce <= 1'b0;
        wr(FFC_ADDR_FMT, 8'h11);
        ce <= 1'b1;
        rd(FFC_ADDR_FMT, d8);
        `CHK(d8, 8'h5C)
        @(posedge clk);
        lowpwr <= 1'b1;
        @(posedge clk);
        lowpwr <= 1'b0;
        rd(FFC_ADDR_FMT, d8);
        `CHK(d8, FFC_FMT_RESET)
        // Reset in mid-run, held for one edge
        wr(FFC_ADDR_FMT, 8'h5C);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rd(FFC_ADDR_FMT, d8);
        `CHK(d8, FFC_FMT_RESET)
        `CHK({txd, buf_ready, sck_oe, sck}, 4'hD)
        summarize();
    end
endmodule
`default_nettype wire
